// *** rtl/ccs_top.v ***
// control, status, timing and diagnosis registers of a transmitting can node
// assumes core event inputs are one-cycle pulses on clk_i; bus_rx_i is a pin
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defs.vh"

module ccs_top (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  input  wire        bus_rx_i,
  input  wire        xfer_busy_i,
  input  wire        rx_ok_i,
  input  wire        rx_own_i,
  input  wire        rx_err_i,
  input  wire        rx_err_big_i,
  input  wire        tx_ok_i,
  input  wire        arb_won_i,
  input  wire        tx_err_i,
  input  wire        overrun_i,
  input  wire        frame_seen_i,
  input  wire [10:0] frame_ident_i,
  input  wire        frame_remote_i,
  input  wire [3:0]  frame_length_i,
  output reg         rx_irq_o,
  output reg         tx_irq_o,
  output reg         sc_irq_o,
  output reg         or_irq_o,
  output reg         te_irq_o,
  output reg         state_change_flag_o,
  output reg         retry_o,
  output reg         bus_on_o,
  output reg         wake_dom_o,
  output reg         self_receive_enable_o,
  output reg         no_retry_opt_o,
  output reg  [1:0]  resync_jump_width_o,
  output reg  [2:0]  page_o,
  output wire        tq_tick_o,
  output wire        sample_tick_o
);

  localparam [2:0] ST_STBY = 3'd0;
  localparam [2:0] ST_WAKE = 3'd1;
  localparam [2:0] ST_SYNC = 3'd2;
  localparam [2:0] ST_RUN  = 3'd3;
  localparam [2:0] ST_STOP = 3'd4;

  reg  [6:0]  icr_q, btr_q;
  reg  [3:0]  cfg_q, run_bits_q;
  reg  [7:0]  quantum_prescaler_config_q, lidh_q, lidl_q, rec_q, seqs_q, rd_mux;
  reg  [8:0]  tec_q;
  reg  [2:0]  psr_q, st_q;
  reg         bus_off_state_q, error_passive_state_q, recov_q, rx_meta_q, rx_sync_q, rx_prev_q;
  wire        bit_tick, samp, standby, wr_icr, wr_csr, wr_win, sync_done;
  wire        bus_off_state_d, error_passive_state_d, sc_evt, tx_evt, rx_evt;
  wire [9:0]  tec_inc;
  wire [8:0]  rec_inc;

  // ================================================================
  // address decode
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction
  assign standby = (st_q == ST_STBY);
  assign wr_icr  = wr_i && hit(addr_i, `CCS_ADDR_ICR);
  assign wr_csr  = wr_i && hit(addr_i, `CCS_ADDR_CSR);
  assign wr_win  = wr_i && (addr_i[7:4] == `CCS_WIN_BASE) && (psr_q == `CCS_PAGE_DIAG);

  // ================================================================
  // bus pin synchroniser
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      {rx_prev_q, rx_sync_q, rx_meta_q} <= 3'b111;
    end
    else
    begin
      {rx_prev_q, rx_sync_q, rx_meta_q} <= {rx_sync_q, rx_meta_q, bus_rx_i};
    end
  end

  // ================================================================
  // bit timing
  ccs_bit_timer u_timer (
    .clk_i         (clk_i),
    .rstn_i        (rstn_i),
    .prescale_i    (quantum_prescaler_config_q[5:0]),
    .seg_one_i     (btr_q[3:0]),
    .seg_two_i     (btr_q[6:4]),
    .tq_tick_o     (tq_tick_o),
    .sample_tick_o (samp),
    .bit_tick_o    (bit_tick)
  );
  assign sample_tick_o = samp;

  // ================================================================
  // configuration registers
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      icr_q  <= `CCS_ICR_RST;
      cfg_q  <= `CCS_CSR_RST;
      quantum_prescaler_config_q <= `CCS_QUANTUM_PRESCALER_CONFIG_RST;
      btr_q  <= `CCS_BTR_RST;
      psr_q  <= `CCS_PSR_RST;
    end
    else if (wr_i)
    begin
      if (wr_icr)
        icr_q <= wdata_i[6:0];
      if (wr_csr)
        cfg_q <= wdata_i[4:1];
      if (hit(addr_i, `CCS_ADDR_QUANTUM_PRESCALER_CONFIG) && standby)
        quantum_prescaler_config_q <= wdata_i;
      if (hit(addr_i, `CCS_ADDR_BTR) && standby)
        btr_q <= wdata_i[6:0];
      if (hit(addr_i, `CCS_ADDR_PSR))
        psr_q <= wdata_i[2:0];
    end
  end

  // ================================================================
  // node mode sequencer
  assign sync_done = samp && rx_sync_q && (run_bits_q == `CCS_RUN_BITS - 4'd1) &&
                     (cfg_q[`CCS_CFG_FAST_RESYNC_OPT] || (seqs_q == `CCS_RUN_SEQS - 8'd1));
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st_q       <= ST_STBY;
      recov_q    <= 1'b0;
      run_bits_q <= 4'h0;
      seqs_q     <= 8'h00;
    end
    else
    begin
      if (samp && st_q == ST_SYNC)
      begin
        if (!rx_sync_q)
          run_bits_q <= 4'h0;
        else if (run_bits_q == `CCS_RUN_BITS - 4'd1)
        begin
          run_bits_q <= 4'h0;
          seqs_q     <= seqs_q + 8'd1;
        end
        else
          run_bits_q <= run_bits_q + 4'd1;
      end
      case (st_q)
        ST_STBY:
        begin
          run_bits_q <= 4'h0;
          seqs_q     <= 8'h00;
          if (wr_csr && wdata_i[`CCS_CSR_RUN])
            st_q <= wdata_i[`CCS_CFG_WAKE_PULSE_OPT + 1] ? ST_WAKE : ST_SYNC;
        end
        ST_WAKE:
          if (wr_csr && !wdata_i[`CCS_CSR_RUN])
            st_q <= ST_STBY;
          else if (bit_tick)
            st_q <= ST_SYNC;
        ST_SYNC:
          if (wr_csr && !wdata_i[`CCS_CSR_RUN] && !recov_q)
            st_q <= ST_STBY;
          else if (sync_done)
          begin
            st_q    <= ST_RUN;
            recov_q <= 1'b0;
          end
        ST_RUN:
          if (bus_off_state_d)
          begin
            st_q    <= ST_SYNC;
            recov_q <= 1'b1;
            seqs_q  <= 8'h00;
          end
          else if (wr_csr && !wdata_i[`CCS_CSR_RUN])
            st_q <= ST_STOP;
        ST_STOP:
          if (!xfer_busy_i)
            st_q <= ST_STBY;
        default:
          st_q <= ST_STBY;
      endcase
    end
  end

  // ================================================================
  // fault confinement counters
  assign tec_inc = {1'b0, tec_q} + `CCS_TEC_STEP;
  assign rec_inc = {1'b0, rec_q} + (rx_err_big_i ? 9'h008 : 9'h001);
  assign bus_off_state_d  = tec_q[8];
  assign error_passive_state_d  = !tec_q[8] && ((tec_q > {1'b0, `CCS_PASSIVE_LIM}) ||
                                 (rec_q > `CCS_PASSIVE_LIM));
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      tec_q <= 9'h000;
      rec_q <= 8'h00;
    end
    else if (recov_q && sync_done)
    begin
      tec_q <= 9'h000;
      rec_q <= 8'h00;
    end
    else if (!bus_off_state_d)
    begin
      if (tx_err_i)
        tec_q <= (tec_inc >= {1'b0, `CCS_TEC_OFF}) ? `CCS_TEC_OFF : tec_inc[8:0];
      else if (tx_ok_i && tec_q != 9'h000)
        tec_q <= tec_q - 9'h001;
      if (rx_err_i)
        rec_q <= (rec_inc > `CCS_REC_MAX) ? 8'hff : rec_inc[7:0];
      else if (rx_ok_i && rec_q > `CCS_REC_HIGH)
        rec_q <= `CCS_REC_RELOAD;
      else if (rx_ok_i && rec_q != 8'h00)
        rec_q <= rec_q - 8'h01;
    end
  end

  // ================================================================
  // diagnosis page
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      lidh_q <= 8'h00;
      lidl_q <= 8'h00;
    end
    else if (frame_seen_i)
    begin
      lidh_q <= frame_ident_i[10:3];
      lidl_q <= {frame_ident_i[2:0], frame_remote_i, frame_length_i};
    end
    else if (wr_win)
    begin
      if (addr_i[3:0] == `CCS_WIN_LIDH)
        lidh_q <= wdata_i;
      if (addr_i[3:0] == `CCS_WIN_LIDL)
        lidl_q <= wdata_i;
    end
  end

  // ================================================================
  // event requests
  assign sc_evt = (!standby && ((bus_off_state_d != bus_off_state_q) || (error_passive_state_d != error_passive_state_q))) ||
                  (standby && rx_prev_q && !rx_sync_q) ||
                  (icr_q[`CCS_ICR_EXTENDED_STATUS_IRQ_OPT] && rx_err_i);
  assign tx_evt = icr_q[`CCS_ICR_ETX] ? arb_won_i : tx_ok_i;
  assign rx_evt = rx_ok_i && (!rx_own_i || cfg_q[`CCS_CFG_SELF_RECEIVE_ENABLE]);
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      bus_off_state_q              <= 1'b0;
      error_passive_state_q              <= 1'b0;
      rx_irq_o            <= 1'b0;
      tx_irq_o            <= 1'b0;
      sc_irq_o            <= 1'b0;
      or_irq_o            <= 1'b0;
      te_irq_o            <= 1'b0;
      state_change_flag_o <= 1'b0;
      retry_o             <= 1'b0;
      bus_on_o            <= 1'b0;
      wake_dom_o          <= 1'b0;
    end
    else
    begin
      bus_off_state_q              <= bus_off_state_d;
      error_passive_state_q              <= error_passive_state_d;
      rx_irq_o            <= rx_evt && icr_q[`CCS_ICR_RECEIVE_IRQ_ENABLE];
      tx_irq_o            <= tx_evt && icr_q[`CCS_ICR_TRANSMIT_IRQ_ENABLE];
      sc_irq_o            <= sc_evt && icr_q[`CCS_ICR_STATE_CHANGE_IRQ_ENABLE];
      or_irq_o            <= overrun_i && icr_q[`CCS_ICR_OVERFLOW_IRQ_ENABLE];
      te_irq_o            <= tx_err_i && icr_q[`CCS_ICR_TX_FAULT_IRQ_ENABLE];
      state_change_flag_o <= sc_evt;
      retry_o             <= tx_err_i && !cfg_q[`CCS_CFG_NO_RETRY_OPT] && !bus_off_state_d;
      bus_on_o            <= ((st_q == ST_RUN) || (st_q == ST_STOP)) && !bus_off_state_d;
      wake_dom_o          <= (st_q == ST_WAKE);
    end
  end

  // ================================================================
  // configuration outputs and read port
  always @*
  begin
    rd_mux = 8'h00;
    case (addr_i)
      `CCS_ADDR_ICR:  rd_mux = {1'b0, icr_q};
      `CCS_ADDR_CSR:  rd_mux = {1'b0, bus_off_state_q, error_passive_state_q, cfg_q, !standby};
      `CCS_ADDR_QUANTUM_PRESCALER_CONFIG: rd_mux = quantum_prescaler_config_q;
      `CCS_ADDR_BTR:  rd_mux = {1'b0, btr_q};
      `CCS_ADDR_PSR:  rd_mux = {5'h00, psr_q};
      default:
      begin
        if (addr_i[7:4] == `CCS_WIN_BASE && psr_q == `CCS_PAGE_DIAG)
        begin
          case (addr_i[3:0])
            `CCS_WIN_LIDH: rd_mux = lidh_q;
            `CCS_WIN_LIDL: rd_mux = lidl_q;
            `CCS_WIN_TEC:  rd_mux = tec_q[7:0];
            `CCS_WIN_REC:  rd_mux = rec_q;
            default:       rd_mux = 8'h00;
          endcase
        end
      end
    endcase
  end
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_o               <= 8'h00;
      self_receive_enable_o <= 1'b0;
      no_retry_opt_o        <= 1'b0;
      resync_jump_width_o   <= 2'b00;
      page_o                <= `CCS_PSR_RST;
    end
    else
    begin
      rdata_o               <= rd_i ? rd_mux : 8'h00;
      self_receive_enable_o <= cfg_q[`CCS_CFG_SELF_RECEIVE_ENABLE];
      no_retry_opt_o        <= cfg_q[`CCS_CFG_NO_RETRY_OPT];
      resync_jump_width_o   <= quantum_prescaler_config_q[7:6];
      page_o                <= psr_q;
    end
  end

endmodule // ccs_top
`default_nettype wire

// *** rtl/ccs_defs.vh ***
// constants for the can control and status register block
// assumes an 8-bit register port and a 250 MHz system clock
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH

// ==================================================================
// register offsets
`define CCS_ADDR_ICR      8'h0b
`define CCS_ADDR_CSR      8'h0c
`define CCS_ADDR_QUANTUM_PRESCALER_CONFIG     8'h0d
`define CCS_ADDR_BTR      8'h0e
`define CCS_ADDR_PSR      8'h0f
`define CCS_WIN_BASE      4'h1
`define CCS_WIN_LIDH      4'h0
`define CCS_WIN_LIDL      4'h1
`define CCS_WIN_TEC       4'he
`define CCS_WIN_REC       4'hf

// ==================================================================
// reset values and masks
`define CCS_ICR_RST       7'h00
`define CCS_CSR_RST       4'h0
`define CCS_QUANTUM_PRESCALER_CONFIG_RST      8'h00
`define CCS_BTR_RST       7'h23
`define CCS_PSR_RST       3'h0
`define CCS_PAGE_DIAG     3'h0

// ==================================================================
// field positions
`define CCS_ICR_ETX       0
`define CCS_ICR_TX_FAULT_IRQ_ENABLE      1
`define CCS_ICR_OVERFLOW_IRQ_ENABLE      2
`define CCS_ICR_STATE_CHANGE_IRQ_ENABLE      3
`define CCS_ICR_TRANSMIT_IRQ_ENABLE      4
`define CCS_ICR_RECEIVE_IRQ_ENABLE      5
`define CCS_ICR_EXTENDED_STATUS_IRQ_OPT      6
`define CCS_CSR_RUN       0
`define CCS_CFG_WAKE_PULSE_OPT      0
`define CCS_CFG_FAST_RESYNC_OPT      1
`define CCS_CFG_NO_RETRY_OPT      2
`define CCS_CFG_SELF_RECEIVE_ENABLE      3

// ==================================================================
// fault confinement figures
`define CCS_TEC_STEP      10'd8
`define CCS_TEC_OFF       9'h100
`define CCS_PASSIVE_LIM   8'd127
`define CCS_REC_HIGH      8'd128
`define CCS_REC_RELOAD    8'd120
`define CCS_REC_MAX       9'h0ff

// ==================================================================
// resynchronisation after standby or bus-off
`define CCS_RUN_BITS      4'd11
`define CCS_RUN_SEQS      8'd128
`define CCS_SEG_EXTRA     5'd3

`endif

// *** rtl/ccs_bit_timer.v ***
// time quantum prescaler and nominal bit sequencer
// assumes stable timing fields, changed only in standby
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defs.vh"

module ccs_bit_timer (
  input  wire       clk_i,
  input  wire       rstn_i,
  input  wire [5:0] prescale_i,
  input  wire [3:0] seg_one_i,
  input  wire [2:0] seg_two_i,
  output reg        tq_tick_o,
  output reg        sample_tick_o,
  output reg        bit_tick_o
);

  reg  [5:0] pre_q;
  reg  [4:0] quant_q;
  wire [4:0] last_quant;
  wire [4:0] sample_quant;

  // ================================================================
  // quantum and bit position
  assign last_quant   = {1'b0, seg_one_i} + {2'b00, seg_two_i} + `CCS_SEG_EXTRA - 5'd1;
  assign sample_quant = {1'b0, seg_one_i} + 5'd1;

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pre_q         <= 6'h00;
      quant_q       <= 5'h00;
      tq_tick_o     <= 1'b0;
      sample_tick_o <= 1'b0;
      bit_tick_o    <= 1'b0;
    end
    else
    begin
      tq_tick_o     <= 1'b0;
      sample_tick_o <= 1'b0;
      bit_tick_o    <= 1'b0;
      if (pre_q == prescale_i)
      begin
        pre_q     <= 6'h00;
        tq_tick_o <= 1'b1;
        if (quant_q == sample_quant)
          sample_tick_o <= 1'b1;
        if (quant_q >= last_quant)
        begin
          quant_q    <= 5'h00;
          bit_tick_o <= 1'b1;
        end
        else
          quant_q <= quant_q + 5'd1;
      end
      else
        pre_q <= pre_q + 6'd1;
    end
  end

endmodule // ccs_bit_timer

`default_nettype wire

// *** testbench/ccs_top_checker.sv ***
// checker: cause-to-effect relations at the register block ports
// assumes binding to ccs_top, one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defs.vh"

module ccs_top_checker (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rx_ok_i,
  input wire logic       tx_ok_i,
  input wire logic       arb_won_i,
  input wire logic       tx_err_i,
  input wire logic       overrun_i,
  input wire logic       rx_irq_o,
  input wire logic       tx_irq_o,
  input wire logic       or_irq_o,
  input wire logic       te_irq_o,
  input wire logic       retry_o,
  input wire logic       bus_on_o,
  input wire logic       wake_dom_o,
  input wire logic [2:0] page_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ==================================================================
  // named steps
  sequence s_page_wr;
    wr_i && addr_i == `CCS_ADDR_PSR;
  endsequence

  // ==================================================================
  // requests follow their cause by one cycle; page_o follows a page write by two
  a_rx_irq_cause: assert property (rx_irq_o |-> $past(rx_ok_i))
    else $error("receive request without reception");
  a_tx_irq_cause: assert property (tx_irq_o |-> $past(tx_ok_i) || $past(arb_won_i))
    else $error("transmit request without cause");
  a_or_irq_cause: assert property (or_irq_o |-> $past(overrun_i))
    else $error("overrun request without overrun");
  a_te_irq_cause: assert property (te_irq_o |-> $past(tx_err_i))
    else $error("transmit error request without error");
  a_retry_cause: assert property (retry_o |-> $past(tx_err_i))
    else $error("retry without failed frame");
  a_wake_off_bus: assert property (wake_dom_o |-> !bus_on_o)
    else $error("wake pulse while on bus");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read answer");
  a_page_write: assert property (s_page_wr |-> ##2 page_o == $past(wdata_i[2:0], 2))
    else $error("page select not taken");
endmodule // ccs_top_checker
`default_nettype wire

// *** testbench/ccs_bus_node.sv ***
// far side: other nodes sharing the wired-and line
// assumes a pull-up; the block's wake pulse joins the line
`timescale 1ns/1ps
`default_nettype none

module ccs_bus_node (
  input  wire logic dom_i,
  input  wire logic wake_dom_i,
  output wire logic rx_o
);
  // ==================================================================
  // released line reads recessive high
  assign rx_o = !(dom_i || wake_dom_i);
endmodule // ccs_bus_node
`default_nettype wire

// *** testbench/ccs_top_tb.sv ***
// self-checking bench for the can control and status registers
// assumes ccs_top at 250 MHz with synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module ccs_top_tb;
  logic        clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, busy = 0, dom = 0;
  logic        rx, wake, on, tq, st, self_receive_enable, no_retry_opt;
  logic [7:0]  addr_i = 0, wdata_i = 0, rdata_o;
  logic [8:0]  ev = 0;
  logic [6:0]  o;
  logic [1:0]  resync_jump_width;
  logic [2:0]  pg;
  int          n_errors = 0, samples_checked = 0, n;
  wire  [4:0]  w = {o[5], on, wake, st, tq};

  always #2 clk_i = ~clk_i;

  ccs_bus_node peer_u (.dom_i(dom), .wake_dom_i(wake), .rx_o(rx));
  ccs_top dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bus_rx_i(rx), .xfer_busy_i(busy),
    .rx_ok_i(ev[0]), .rx_own_i(ev[1]), .rx_err_i(ev[2]), .rx_err_big_i(ev[3]),
    .tx_ok_i(ev[4]), .arb_won_i(ev[5]), .tx_err_i(ev[6]), .overrun_i(ev[7]),
    .frame_seen_i(ev[8]), .frame_ident_i(11'h5a3), .frame_remote_i(1'b1),
    .frame_length_i(4'h8), .rx_irq_o(o[0]), .tx_irq_o(o[1]), .sc_irq_o(o[2]),
    .or_irq_o(o[3]), .te_irq_o(o[4]), .state_change_flag_o(o[5]), .retry_o(o[6]),
    .bus_on_o(on), .wake_dom_o(wake), .self_receive_enable_o(self_receive_enable), .no_retry_opt_o(no_retry_opt),
    .resync_jump_width_o(resync_jump_width), .page_o(pg), .tq_tick_o(tq), .sample_tick_o(st));

  // ==================================================================
  // bus, event and wait tasks
  task final_report;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1;
    `CHK(rdata_o, e)
  endtask
  task pl(input logic [8:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 0;
    #1;
  endtask
  task evc(input logic [8:0] m, input logic [6:0] e);
    pl(m);
    `CHK(o, e)
  endtask
  task wt(input int s, input int lim, output int c);
    c = 0;
    while (w[s] !== 1'b1)
    begin
      if (c >= lim)
      begin
        n_errors++;
        final_report;
      end
      @(posedge clk_i);
      #1;
      c++;
    end
  endtask
  task gap(input int s, output int c);
    wt(s, 500, c);
    @(posedge clk_i);
    #1;
    wt(s, 500, c);
    c++;
  endtask

  // ==================================================================
  // main sequence
  initial
  begin
    #300000;
    n_errors++;
    final_report;
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1;
    rd(`CCS_ADDR_ICR, 8'h00);
    rd(`CCS_ADDR_CSR, 8'h00);
    rd(`CCS_ADDR_QUANTUM_PRESCALER_CONFIG, 8'h00);
    rd(`CCS_ADDR_BTR, 8'h23);
    rd(`CCS_ADDR_PSR, 8'h00);
    rd(8'h1e, 8'h00);
    rd(8'h1f, 8'h00);
    rd(8'h00, 8'h00);
    wr(`CCS_ADDR_QUANTUM_PRESCALER_CONFIG, 8'h42);
    rd(`CCS_ADDR_QUANTUM_PRESCALER_CONFIG, 8'h42);
    `CHK(resync_jump_width, 2'h1)
    gap(0, n);
    gap(0, n);
    `CHK(n, 3)
    gap(1, n);
    gap(1, n);
    `CHK(n, 24)
    wr(`CCS_ADDR_BTR, 8'h12);
    rd(`CCS_ADDR_BTR, 8'h12);
    gap(1, n);
    gap(1, n);
    `CHK(n, 18)
    wr(`CCS_ADDR_QUANTUM_PRESCALER_CONFIG, 8'h40);
    wr(`CCS_ADDR_ICR, 8'hff);
    rd(`CCS_ADDR_ICR, 8'h7f);
    evc(9'h001, 7'h01);
    evc(9'h020, 7'h02);
    evc(9'h080, 7'h08);
    evc(9'h040, 7'h50);
    evc(9'h004, 7'h24);
    evc(9'h00c, 7'h24);
    rd(8'h1f, 8'h09);
    rd(8'h1e, 8'h08);
    evc(9'h003, 7'h00);
    wr(`CCS_ADDR_ICR, 8'h3e);
    evc(9'h010, 7'h02);
    evc(9'h020, 7'h00);
    evc(9'h004, 7'h00);
    wr(`CCS_ADDR_ICR, 8'h00);
    evc(9'h001, 7'h00);
    evc(9'h040, 7'h40);
    wr(`CCS_ADDR_CSR, 8'h08);
    evc(9'h040, 7'h00);
    rd(8'h1e, 8'h17);
    wr(`CCS_ADDR_ICR, 8'h20);
    wr(`CCS_ADDR_CSR, 8'h18);
    evc(9'h003, 7'h01);
    `CHK({self_receive_enable, no_retry_opt}, 2'b11)
    evc(9'h100, 7'h00);
    rd(8'h10, 8'hb4);
    rd(8'h11, 8'h78);
    wr(`CCS_ADDR_PSR, 8'h01);
    @(posedge clk_i);
    #1;
    `CHK(pg, 3'h1)
    rd(8'h10, 8'h00);
    wr(`CCS_ADDR_PSR, 8'h00);
    wr(`CCS_ADDR_ICR, 8'h08);
    wr(`CCS_ADDR_CSR, 8'h00);
    dom <= 1;
    wt(4, 20, n);
    `CHK(o[2], 1'b1)
    @(posedge clk_i);
    dom <= 0;
    wr(`CCS_ADDR_CSR, 8'h07);
    wt(2, 20, n);
    `CHK(wake, 1'b1)
    wt(3, 400, n);
    `CHK((n >= 60) && (n <= 80), 1'b1)
    rd(`CCS_ADDR_CSR, 8'h07);
    wr(`CCS_ADDR_QUANTUM_PRESCALER_CONFIG, 8'h55);
    rd(`CCS_ADDR_QUANTUM_PRESCALER_CONFIG, 8'h40);
    repeat (14) pl(9'h040);
    rd(`CCS_ADDR_CSR, 8'h27);
    repeat (16) pl(9'h040);
    rd(`CCS_ADDR_CSR, 8'h47);
    `CHK(on, 1'b0)
    wt(3, 400, n);
    rd(8'h1e, 8'h00);
    rd(`CCS_ADDR_CSR, 8'h07);
    @(posedge clk_i);
    busy <= 1;
    wr(`CCS_ADDR_CSR, 8'h06);
    rd(`CCS_ADDR_CSR, 8'h07);
    @(posedge clk_i);
    busy <= 0;
    repeat (3) @(posedge clk_i);
    rd(`CCS_ADDR_CSR, 8'h06);
    `CHK(on, 1'b0)
    `CHK({self_receive_enable, no_retry_opt}, 2'b00)
    final_report;
  end
endmodule // ccs_top_tb

bind ccs_top ccs_top_checker chk_u (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .rx_ok_i, .tx_ok_i, .arb_won_i, .tx_err_i, .overrun_i, .rx_irq_o, .tx_irq_o,
  .or_irq_o, .te_irq_o, .retry_o, .bus_on_o, .wake_dom_o, .page_o);
`default_nettype wire
